// *** logic/vss_pkg.sv ***
package vss_pkg;
    // Clock and master tick
    localparam int CLK_HZ = 40000000;
    localparam int TICK_MS = 10;
    localparam int TICK_CYC_DEF = CLK_HZ / 1000 * TICK_MS;
    // Supervision times in ms and their tick counts
    localparam int WIN_MS = 500;
    localparam logic [7:0] WIN_TICKS = 8'(WIN_MS / TICK_MS);
    localparam int GRACE_MS = 1280;
    localparam logic [7:0] GRACE_TICKS = 8'(GRACE_MS / TICK_MS);
    localparam int FSK_LOSS_MS = 30;
    localparam int FSK_STOP_MS = 50;
    // Trips between 30 and 40 ms after the last edge, inside the 50 ms bound
    localparam logic [2:0] FSK_TRIP = 3'(FSK_LOSS_MS / TICK_MS + 1);
    localparam int RAMP_MS = 62;
    localparam logic [3:0] RAMP_TICKS = 4'(RAMP_MS / TICK_MS);
    localparam logic [2:0] HOLD_PER_UNIT = 3'h2;
    // Clock supervision against an independent reference
    localparam int REF_HZ = 100000;
    localparam int GATE_MS = 1000;
    localparam logic [6:0] GATE_TICKS = 7'(GATE_MS / TICK_MS);
    localparam int REF_EXPECT_DEF = REF_HZ / 1000 * GATE_MS;
    localparam int REF_TOL_DEF = REF_EXPECT_DEF / 5000;
    // Speed words in 0.5 ft/s units
    localparam logic [7:0] TURN_MAX_SPD = 8'h31;
    // Register map (word index on the plain port)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_TURNOUT = 4'h1;
    localparam logic [3:0] REG_LIMIT = 4'h2;
    localparam logic [3:0] REG_SPEED = 4'h3;
    localparam logic [3:0] REG_BATT = 4'h4;
    localparam logic [3:0] REG_FAULT = 4'h5;
    localparam logic [3:0] REG_MON = 4'h6;
    localparam logic [3:0] REG_STATE = 4'h7;
    // Field positions
    localparam int CTRL_REV_BIT = 0;
    localparam int TURN_DIR_BIT = 0;
    localparam int TURN_TAG_BIT = 1;
    // Reset values
    localparam logic [7:0] LIMIT_RST = 8'h00;
    localparam logic [7:0] BATT_HI_RST = 8'hFF;
    localparam logic [7:0] BATT_LO_RST = 8'h00;
    localparam logic [7:0] DAC_START = 8'h80;
    // Fault bit positions
    localparam int F_EXIT = 0;
    localparam int F_STEER = 1;
    localparam int F_FSK = 2;
    localparam int F_SPEED = 3;
    localparam int F_CLOCK = 4;
    localparam int F_ACCUM = 5;
    localparam int F_FLUID = 6;
    localparam int F_PAD = 7;
    localparam int F_BATT = 8;
    localparam int F_LOAD = 9;
    localparam int NFAULT = 10;

    typedef enum logic [4:0] {
        STOP_NONE = 5'b00001,
        STOP_REV = 5'b00010,
        STOP_IRR = 5'b00100,
        STOP_CLE = 5'b01000,
        STOP_OLE = 5'b10000
    } vss_stop_e;
endpackage

// *** logic/vss_supervisor.sv ***
// Local design decisions: the register offsets and strobed register access.
`timescale 1ns/1ps
module vss_supervisor
    import vss_pkg::*;
#(
    parameter int TICK_CYC = TICK_CYC_DEF,
    parameter int REF_EXPECT = REF_EXPECT_DEF,
    parameter int REF_TOL = REF_TOL_DEF
)(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    // Vehicle pins
    input wire logic fskDataClk,
    input wire logic loopEntry,
    input wire logic turnTrigger,
    input wire logic steerFbLeft,
    input wire logic steerFbRight,
    input wire logic exitClosed,
    input wire logic accumLow,
    input wire logic fluidHot,
    input wire logic padHot,
    input wire logic suspLoopClosed,
    input wire logic refClk,
    input wire logic brakeCmp,
    input wire logic nvDirIn,
    input wire logic [7:0] propTorque,
    input wire logic [7:0] propStatus,
    input wire logic [7:0] battWord,
    // Steering and retained direction
    output logic steerLeft,
    output logic steerRight,
    output logic nvDirOut,
    // Collision avoidance channels
    output logic [7:0] odoSpeedA,
    output logic biasLeftA,
    output logic [7:0] odoSpeedB,
    output logic biasLeftB,
    // Ticks to both processors
    output logic tickA,
    output logic tickB,
    // Stopping and reporting
    output logic [4:0] stopMode,
    output logic propulsionOff,
    output logic brakeHoldOff,
    output logic [7:0] brakeDac,
    output logic faultStrobe,
    output logic [NFAULT-1:0] faultCode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    localparam int NSYNC = 37;
    logic [NSYNC-1:0] syncA, syncB;
    logic [NSYNC-1:0] pinsIn;
    logic fskPrevQ, loopPrevQ, trigPrevQ, refPrevQ;
    logic [18:0] divQ;
    logic tickEn;
    vss_stop_e modeQ;
    logic [7:0] winQ, graceQ, speedQ, limitQ, targetQ, battHiQ, battLoQ;
    logic [9:0] holdQ;
    logic [3:0] rampQ;
    logic [2:0] fskCntQ, sarIdxQ;
    logic [6:0] gateQ;
    logic [17:0] refCntQ;
    logic dirQ, dirChkQ, dirValidQ, revReqQ, clkFailQ, battBadQ;
    logic [1:0] initCntQ;
    logic [7:0] brakeWordQ, propTorqueQ, propStatusQ, battQ, sarMask, sarTrial;
    logic [NFAULT-1:0] faultQ, faultEv, faultRaw;
    logic [31:0] rdataQ;
    logic verOk, issue, olReq, ceReq, irrReq, fskRise, trigRise, moving;

    assign pinsIn = {battWord, propStatus, propTorque, nvDirIn, brakeCmp, refClk,
                     suspLoopClosed, padHot, fluidHot, accumLow, exitClosed,
                     steerFbRight, steerFbLeft, turnTrigger, loopEntry, fskDataClk};

    // Two-stage synchroniser on every pin input
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= pinsIn;
            syncB <= syncA;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            fskPrevQ <= 1'b0;
            loopPrevQ <= 1'b0;
            trigPrevQ <= 1'b0;
            refPrevQ <= 1'b0;
        end else begin
            fskPrevQ <= syncB[0];
            loopPrevQ <= syncB[1];
            trigPrevQ <= syncB[2];
            refPrevQ <= syncB[10];
        end
    end
    assign fskRise = syncB[0] & ~fskPrevQ;
    assign trigRise = syncB[2] & ~trigPrevQ;
    assign verOk = syncB[3] ^ syncB[4];
    assign moving = speedQ != 8'h00;

    // Single divider makes the 10 ms tick for both channels
    assign tickEn = divQ == 19'(TICK_CYC - 1);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            divQ <= '0;
            tickA <= 1'b0;
            tickB <= 1'b0;
        end else begin
            divQ <= tickEn ? '0 : divQ + 19'h1;
            tickA <= tickEn;
            tickB <= tickEn;
        end
    end

    // Turnout direction latch and selection window
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            winQ <= '0;
            dirQ <= 1'b0;
            dirChkQ <= 1'b0;
            dirValidQ <= 1'b0;
        end else begin
            if (syncB[1] && !loopPrevQ)
                winQ <= WIN_TICKS;
            else if (tickEn && winQ != 8'h00)
                winQ <= winQ - 8'h01;
            if (initCntQ == 2'h2) begin
                dirQ <= syncB[12];
                dirChkQ <= syncB[12];
            end else if (regWr && regAddr == REG_TURNOUT &&
                         (regWdata[TURN_TAG_BIT] || winQ != 8'h00)) begin
                dirQ <= regWdata[TURN_DIR_BIT];
                dirChkQ <= regWdata[TURN_DIR_BIT];
                dirValidQ <= 1'b1;
            end
        end
    end

    assign issue = trigRise && dirValidQ && limitQ <= TURN_MAX_SPD;

    // Steering command, retained direction and verification grace
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            initCntQ <= '0;
            steerLeft <= 1'b0;
            steerRight <= 1'b0;
            nvDirOut <= 1'b0;
            graceQ <= '0;
        end else begin
            if (initCntQ != 2'h3)
                initCntQ <= initCntQ + 2'h1;
            if (initCntQ == 2'h2) begin
                steerLeft <= syncB[12];
                steerRight <= ~syncB[12];
                nvDirOut <= syncB[12];
            end else if (issue && dirQ == dirChkQ) begin
                steerLeft <= dirQ;
                steerRight <= ~dirQ;
                nvDirOut <= dirQ;
                if (dirQ != nvDirOut)
                    graceQ <= GRACE_TICKS;
            end else if (tickEn && graceQ != 8'h00) begin
                graceQ <= graceQ - 8'h01;
            end
        end
    end

    // Dual odometer and bias channels
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            odoSpeedA <= '0;
            odoSpeedB <= '0;
            biasLeftA <= 1'b0;
            biasLeftB <= 1'b0;
        end else begin
            odoSpeedA <= speedQ;
            odoSpeedB <= speedQ;
            if (verOk && syncB[3] == steerLeft && initCntQ == 2'h3) begin
                biasLeftA <= syncB[3];
                biasLeftB <= syncB[3];
            end
        end
    end

    // Safe-to-proceed heartbeat
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            fskCntQ <= '0;
        else if (fskRise)
            fskCntQ <= '0;
        else if (tickEn && fskCntQ != FSK_TRIP)
            fskCntQ <= fskCntQ + 3'h1;
    end

    // Speed limit transitions
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            limitQ <= LIMIT_RST;
            targetQ <= LIMIT_RST;
            holdQ <= '0;
            rampQ <= '0;
        end else if (regWr && regAddr == REG_LIMIT) begin
            targetQ <= regWdata[7:0];
            rampQ <= '0;
            if (regWdata[7:0] >= limitQ) begin
                limitQ <= regWdata[7:0];
                holdQ <= '0;
            end else begin
                holdQ <= 10'(limitQ - regWdata[7:0]) * 10'(HOLD_PER_UNIT);
            end
        end else if (tickEn) begin
            if (holdQ != 10'h000) begin
                holdQ <= holdQ - 10'h001;
            end else if (limitQ > targetQ) begin
                if (rampQ == RAMP_TICKS - 4'h1) begin
                    rampQ <= '0;
                    limitQ <= limitQ - 8'h01;
                end else begin
                    rampQ <= rampQ + 4'h1;
                end
            end
        end
    end

    // Master clock check: reference edges over a gate of master ticks
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gateQ <= '0;
            refCntQ <= '0;
            clkFailQ <= 1'b0;
        end else begin
            if (tickEn && gateQ == GATE_TICKS - 7'h01) begin
                gateQ <= '0;
                refCntQ <= '0;
                if (refCntQ > 18'(REF_EXPECT + REF_TOL) || refCntQ < 18'(REF_EXPECT - REF_TOL))
                    clkFailQ <= 1'b1;
            end else begin
                if (tickEn)
                    gateQ <= gateQ + 7'h01;
                if (syncB[10] && !refPrevQ)
                    refCntQ <= refCntQ + 18'h1;
            end
        end
    end

    // Brake pressure successive approximation, one bit per tick
    assign sarMask = 8'h01 << sarIdxQ;
    assign sarTrial = syncB[11] ? brakeDac : (brakeDac & ~sarMask);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            brakeDac <= DAC_START;
            sarIdxQ <= 3'h7;
            brakeWordQ <= '0;
        end else if (tickEn) begin
            if (sarIdxQ == 3'h0) begin
                brakeWordQ <= sarTrial;
                brakeDac <= DAC_START;
                sarIdxQ <= 3'h7;
            end else begin
                brakeDac <= sarTrial | (sarMask >> 1);
                sarIdxQ <= sarIdxQ - 3'h1;
            end
        end
    end

    // Monitored words sampled on the tick
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            propTorqueQ <= '0;
            propStatusQ <= '0;
            battQ <= '0;
            battBadQ <= 1'b0;
        end else if (tickEn) begin
            propTorqueQ <= syncB[20:13];
            propStatusQ <= syncB[28:21];
            battQ <= syncB[36:29];
            battBadQ <= battQ > battHiQ || battQ < battLoQ;
        end
    end

    // Fault events, held off until the synchronisers carry real pin levels
    assign faultRaw[F_EXIT] = !syncB[5] && moving;
    assign faultRaw[F_STEER] = !verOk && graceQ == 8'h00;
    assign faultRaw[F_FSK] = fskCntQ == FSK_TRIP;
    assign faultRaw[F_SPEED] = speedQ > limitQ;
    assign faultRaw[F_CLOCK] = clkFailQ;
    assign faultRaw[F_ACCUM] = syncB[6];
    assign faultRaw[F_FLUID] = syncB[7];
    assign faultRaw[F_PAD] = syncB[8];
    assign faultRaw[F_BATT] = battBadQ;
    assign faultRaw[F_LOAD] = !syncB[9];
    assign faultEv = faultRaw & {NFAULT{initCntQ == 2'h3}};

    assign olReq = faultEv[F_CLOCK] | faultEv[F_ACCUM];
    assign ceReq = faultEv[F_STEER] | faultEv[F_FSK] | faultEv[F_SPEED];
    assign irrReq = faultEv[F_EXIT] | faultEv[F_FLUID] | faultEv[F_PAD] | faultEv[F_BATT];

    // Stop mode escalation; only reversible stop may be withdrawn
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            modeQ <= STOP_NONE;
        end else begin
            case (modeQ)
                STOP_OLE: modeQ <= STOP_OLE;
                STOP_CLE: modeQ <= olReq ? STOP_OLE : STOP_CLE;
                STOP_IRR: modeQ <= olReq ? STOP_OLE : (ceReq ? STOP_CLE : STOP_IRR);
                STOP_NONE, STOP_REV: begin
                    if (olReq)
                        modeQ <= STOP_OLE;
                    else if (ceReq)
                        modeQ <= STOP_CLE;
                    else if (irrReq)
                        modeQ <= STOP_IRR;
                    else
                        modeQ <= revReqQ ? STOP_REV : STOP_NONE;
                end
                default: modeQ <= STOP_OLE;
            endcase
        end
    end
    assign stopMode = modeQ;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            propulsionOff <= 1'b1;
            brakeHoldOff <= 1'b0;
        end else begin
            propulsionOff <= modeQ != STOP_NONE;
            brakeHoldOff <= modeQ != STOP_OLE;
        end
    end

    // Sticky fault record and downlink report; a new event beats a clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            faultQ <= '0;
            faultStrobe <= 1'b0;
            faultCode <= '0;
        end else begin
            if (regWr && regAddr == REG_FAULT)
                faultQ <= (faultQ & ~regWdata[NFAULT-1:0]) | faultEv;
            else
                faultQ <= faultQ | faultEv;
            faultStrobe <= |(faultEv & ~faultQ);
            faultCode <= faultQ | faultEv;
        end
    end

    // Register writes and reads
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            revReqQ <= 1'b0;
            speedQ <= '0;
            battHiQ <= BATT_HI_RST;
            battLoQ <= BATT_LO_RST;
        end else if (regWr) begin
            case (regAddr)
                REG_CTRL: revReqQ <= regWdata[CTRL_REV_BIT];
                REG_SPEED: speedQ <= regWdata[7:0];
                REG_BATT: begin
                    battHiQ <= regWdata[15:8];
                    battLoQ <= regWdata[7:0];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdataQ <= '0;
        end else if (regRd) begin
            case (regAddr)
                REG_CTRL: rdataQ <= {31'h0, revReqQ};
                REG_TURNOUT: rdataQ <= {24'h0, winQ != 8'h00, steerRight, steerLeft,
                                        verOk, nvDirOut, dirValidQ, 1'b0, dirQ};
                REG_LIMIT: rdataQ <= {8'h00, holdQ[7:0], targetQ, limitQ};
                REG_SPEED: rdataQ <= {24'h0, speedQ};
                REG_BATT: rdataQ <= {16'h0, battHiQ, battLoQ};
                REG_FAULT: rdataQ <= {22'h0, faultQ};
                REG_MON: rdataQ <= {battQ, propStatusQ, propTorqueQ, brakeWordQ};
                REG_STATE: rdataQ <= {27'h0, modeQ};
                default: rdataQ <= 32'h0;
            endcase
        end else begin
            rdataQ <= '0;
        end
    end
    assign regRdata = rdataQ;

    logic initDoneQ;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            initDoneQ <= 1'b0;
        else
            initDoneQ <= initCntQ == 2'h3;
    end

    steer_excl_a: assert property (!(steerLeft && steerRight))
        else $error("steer left and right together");
    steer_gate_a: assert property (initDoneQ && $changed(steerLeft)
        |-> $past(trigRise) && $past(limitQ) <= TURN_MAX_SPD)
        else $error("steer changed without trigger or with high limit");
    feedback_stop_a: assert property (faultEv[F_STEER]
        |=> modeQ == STOP_CLE || modeQ == STOP_OLE)
        else $error("bad steering feedback did not stop");
    grace_load_a: assert property (issue && dirQ == dirChkQ && dirQ != nvDirOut
        && initCntQ == 2'h3 |=> graceQ == GRACE_TICKS)
        else $error("grace not loaded on direction change");
    bias_verified_a: assert property ($changed(biasLeftA) |-> $past(verOk))
        else $error("bias sent without verification");
    exit_stop_a: assert property (faultEv[F_EXIT]
        |=> modeQ != STOP_NONE && modeQ != STOP_REV ##1 faultQ[F_EXIT])
        else $error("exit open while moving not handled");
    irrevocable_a: assert property (modeQ == STOP_IRR
        |=> modeQ != STOP_NONE && modeQ != STOP_REV)
        else $error("irrevocable stop withdrawn");
    open_loop_a: assert property ($rose(modeQ == STOP_OLE) |-> $past(olReq))
        else $error("open-loop stop without braking failure");
    channel_same_a: assert property (odoSpeedA == odoSpeedB && biasLeftA == biasLeftB)
        else $error("collision avoidance channels differ");
    fsk_loss_a: assert property (fskCntQ == FSK_TRIP |=> modeQ inside {STOP_CLE, STOP_OLE})
        else $error("loss of safe-to-proceed not acted on");
    overspeed_a: assert property (speedQ > limitQ |=> modeQ inside {STOP_CLE, STOP_OLE})
        else $error("overspeed not stopped");
    tick_pair_a: assert property (tickA |-> tickB ##1 !tickA)
        else $error("tick channels differ");
    holdoff_drop_a: assert property (modeQ == STOP_OLE |=> !brakeHoldOff)
        else $error("hold-off kept in open-loop stop");

    issue_c: cover property (issue ##1 $changed(steerLeft));
    fsk_loss_c: cover property (fskCntQ == FSK_TRIP);
    ramp_c: cover property (holdQ == 10'h001 && tickEn ##[1:600] $rose(limitQ == targetQ));
    open_loop_c: cover property ($rose(modeQ == STOP_OLE));
endmodule

// *** testbench/vehicle_safety_supervisor_tb.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module vehicle_safety_supervisor_tb;
    import vss_pkg::*;
    int err_count = 0, cmp_count = 0, seed = 7858, n, fb, strobes = 0;
    logic clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, refClk = 1'b0, refOn = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic fskOn = 1'b1, turnTrigger = 1'b0, exitClosed = 1'b1, accumLow = 1'b0;
    logic fluidHot = 1'b0, padHot = 1'b0, loopEntry = 1'b0, suspLoopClosed = 1'b1, brakeCmp;
    logic [7:0] propTorque = 8'h00, propStatus = 8'h00, battWord = 8'h40, pressure = 8'h00;
    logic [12:0] lag = 13'd40;
    logic fskDataClk, steerFbLeft, steerFbRight, steerLeft, steerRight, nvDirOut;
    logic biasLeftA, biasLeftB, tickA, tickB, propulsionOff, brakeHoldOff, faultStrobe;
    logic [7:0] odoSpeedA, odoSpeedB, brakeDac;
    logic [4:0] stopMode;
    logic [NFAULT-1:0] faultCode;
    vss_stop_e expQ[$] = '{STOP_IRR, STOP_IRR, STOP_IRR, STOP_OLE, STOP_CLE, STOP_CLE, STOP_IRR,
                           STOP_OLE};
    int fbQ[$] = '{F_EXIT, F_FLUID, F_PAD, F_ACCUM, F_SPEED, F_FSK, F_BATT, F_CLOCK};
    vss_stop_e ex;
    always #12.5 clk = ~clk;
    always #500 if (refOn) refClk = ~refClk;
    vss_far_side far_u (.clk(clk), .fskOn(fskOn), .lag(lag), .steerLeft(steerLeft),
        .steerRight(steerRight), .pressure(pressure), .brakeDac(brakeDac), .brakeCmp(brakeCmp),
        .fskDataClk(fskDataClk), .steerFbLeft(steerFbLeft), .steerFbRight(steerFbRight));
    vss_supervisor #(.TICK_CYC(40), .REF_EXPECT(100), .REF_TOL(2)) dut_u (.clk(clk),
        .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .fskDataClk(fskDataClk), .loopEntry(loopEntry),
        .turnTrigger(turnTrigger), .steerFbLeft(steerFbLeft), .steerFbRight(steerFbRight),
        .exitClosed(exitClosed), .accumLow(accumLow), .fluidHot(fluidHot), .padHot(padHot),
        .suspLoopClosed(suspLoopClosed), .refClk(refClk), .brakeCmp(brakeCmp), .nvDirIn(1'b1),
        .propTorque(propTorque), .propStatus(propStatus), .battWord(battWord),
        .steerLeft(steerLeft), .steerRight(steerRight), .nvDirOut(nvDirOut),
        .odoSpeedA(odoSpeedA), .biasLeftA(biasLeftA), .odoSpeedB(odoSpeedB),
        .biasLeftB(biasLeftB), .tickA(tickA), .tickB(tickB), .stopMode(stopMode),
        .propulsionOff(propulsionOff), .brakeHoldOff(brakeHoldOff), .brakeDac(brakeDac),
        .faultStrobe(faultStrobe), .faultCode(faultCode));
    // Counts downlink report pulses
    always @(posedge clk) if (faultStrobe) strobes++;
    always @(negedge clk) if (nrst) `CHK({tickA, odoSpeedA, biasLeftA}, {tickB, odoSpeedB, biasLeftB})
    task automatic tally_and_finish();
        if (err_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 `CHK(regRdata, e)
    endtask
    task automatic restart();
        nrst <= 1'b0;
        {exitClosed, fluidHot, padHot, accumLow, fskOn, loopEntry, suspLoopClosed} <= 7'b1000101;
        pressure <= 8'($random(seed));
        propTorque <= 8'($random(seed));
        propStatus <= 8'($random(seed));
        battWord <= {1'b0, 7'($random(seed))} | 8'h01;
        refOn = 1'b1;
        strobes = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    task automatic trigger();
        turnTrigger <= 1'b1;
        repeat (8) @(posedge clk);
        turnTrigger <= 1'b0;
    endtask
    initial begin
        restart();
        rd(REG_STATE, 32'(STOP_NONE));
        rd(4'hF, 32'h0);
        wr(REG_CTRL, 32'h1);
        rd(REG_STATE, 32'(STOP_REV));
        wr(REG_CTRL, 32'h0);
        rd(REG_STATE, 32'(STOP_NONE));
        wr(REG_LIMIT, 32'h40);
        rd(REG_LIMIT, 32'h4040);
        wr(REG_LIMIT, 32'h3E);
        repeat (300) @(posedge clk);
        rd(REG_LIMIT, 32'h3E40);
        repeat (340) @(posedge clk);
        rd(REG_LIMIT, 32'h3E3E);
        for (int i = 0; i < 8; i++) begin
            restart();
            wr(REG_LIMIT, 32'h40);
            wr(REG_SPEED, {26'h0, 6'($random(seed)) | 6'h01});
            repeat (20) @(posedge clk);
            `CHK(stopMode, STOP_NONE)
            case (i)
                0: exitClosed <= 1'b0;
                1: fluidHot <= 1'b1;
                2: padHot <= 1'b1;
                3: accumLow <= 1'b1;
                4: wr(REG_SPEED, 32'h41);
                5: fskOn <= 1'b0;
                6: wr(REG_BATT, {16'h0, battWord - 8'h01, 8'h00});
                default: refOn = 1'b0;
            endcase
            for (n = 0; n < (i == 7 ? 8200 : 210) && stopMode === STOP_NONE; n++) @(posedge clk);
            ex = expQ.pop_front();
            fb = fbQ.pop_front();
            `CHK(stopMode, ex)
            if (i == 5) `CHK(n > 80, 1'b1)
            repeat (2) @(posedge clk);
            `CHK({propulsionOff, brakeHoldOff}, {1'b1, ex != STOP_OLE})
            `CHK({22'h0, faultCode}, 32'h1 << fb)
            `CHK(strobes, 1)
        end
        restart();
        wr(REG_LIMIT, 32'h31);
        wr(REG_TURNOUT, 32'h2);
        trigger();
        `CHK({steerLeft, steerRight}, 2'b01)
        suspLoopClosed <= 1'b0;
        repeat (200) @(posedge clk);
        `CHK({stopMode, biasLeftA, faultCode[F_LOAD]}, {STOP_NONE, 2'b01})
        wr(REG_TURNOUT, 32'h1);
        rd(REG_TURNOUT, 32'h54);
        @(posedge clk);
        loopEntry <= 1'b1;
        lag <= 13'd6000;
        repeat (3) @(posedge clk);
        wr(REG_TURNOUT, 32'h1);
        trigger();
        `CHK({steerLeft, steerRight, nvDirOut}, 3'b101)
        repeat (5000) @(posedge clk);
        `CHK(stopMode, STOP_NONE)
        repeat (300) @(posedge clk);
        `CHK(stopMode, STOP_CLE)
        rd(REG_MON, {battWord, propStatus, propTorque, pressure});
        tally_and_finish();
    end
    initial begin
        #1000000;
        err_count++;
        tally_and_finish();
    end
endmodule

// *** testbench/vss_far_side.sv ***
`timescale 1ns/1ps
module vss_far_side (
    // Bench controls
    input wire logic clk,
    input wire logic fskOn,
    input wire logic [12:0] lag,
    // Steering commands
    input wire logic steerLeft,
    input wire logic steerRight,
    // Caliper pressure and the trial code it is compared against
    input wire logic [7:0] pressure,
    input wire logic [7:0] brakeDac,
    output logic brakeCmp,
    // Wayside clock and steering feedback
    output logic fskDataClk,
    output logic steerFbLeft,
    output logic steerFbRight
);
    logic [3:0] div = 4'h0;
    logic [12:0] cnt = 13'h0;
    initial begin
        fskDataClk = 1'b0;
        {steerFbLeft, steerFbRight} = 2'b10;
    end
    always @(posedge clk) brakeCmp <= pressure >= brakeDac;
    // Heartbeat stands still once the carrier is lost
    always @(posedge clk) begin
        div <= div + 4'h1;
        if (fskOn && div == 4'hF)
            fskDataClk <= ~fskDataClk;
    end
    // Both feedbacks drop while switching, one returns after lag cycles
    always @(posedge clk) begin
        if ((steerLeft ^ steerRight) && {steerFbLeft, steerFbRight} != {steerLeft, steerRight}) begin
            cnt <= cnt + 13'h1;
            {steerFbLeft, steerFbRight} <= (cnt >= lag) ? {steerLeft, steerRight} : 2'b00;
        end else begin
            cnt <= 13'h0;
        end
    end
endmodule
